// ---- twowire_slave.sv ----
// Functional notes
// [R1] Sample data on each rising serial clock
// [R2] Data change while clock high is condition
// [R3] Falling data, clock high: start
// [R4] Rising data, clock high: stop, go idle
// [R5] Acknowledge ninth bit by pulling low
// [R6] Ack general call and own address only
// [R7] Acknowledge even during nonvolatile write
// [R8] Master restarts with start after error
// [R9] Malformed frames or extra conditions abort
// [R10] First byte: seven address bits plus direction
// [R11] Repeated start behaves like start
// [R12] Master code enters high-speed mode, not acknowledged
// [R13] Leave high-speed mode on stop only
// [R14] Standard, fast, and 3.4 MHz clocks
// [R15] Reject clock spikes under 10 ns; code filters the clock in high-speed mode only
// [R16] One general call command, rest refused
// [R17] Zero command invalid, odd is hardware
// [R18] Losing master releases and keeps listening
// [R19] Master repeated start collision rules
// [R20] Data driven only low, only when owed
`timescale 1ns/1ps
module twowire_slave
   import twowire_pkg::*;
   (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [6:0] own_addr,
   input wire logic [7:0] tx_data,
   output logic tx_taken,
   output logic rx_valid,
   input wire logic rx_ready,
   output rx_word_t rx_word,
   output logic hs_mode,
   output logic start_seen,
   output logic stop_seen
   );
   // ***********************************************
   // Declarations
   // ***********************************************
   logic scl_m, scl_s;       // Clock synchroniser
   logic sda_m, sda_s;       // Data synchroniser
   logic scl_f;              // Filtered clock level
   logic [1:0] spike_cnt;    // Clock disagreement run
   logic sda_q;              // Data one cycle ago
   logic scl_fq;             // Filtered clock one cycle ago
   logic scl_rise, scl_fall; // Clock edges
   logic start_ev, stop_ev;  // Bus conditions
   link_state_t state;       // Link state
   logic [3:0] bit_cnt;      // Bits in current byte
   logic [7:0] shreg;        // Receive shift register
   logic [7:0] txsh;         // Transmit shift register
   logic rw;                 // Direction of this frame
   logic [1:0] gc_phase;     // General call progress
   logic first_pend;         // Next data byte is first
   logic push;               // Word offered to buffer
   rx_word_t push_word;      // Word offered
   logic fifo_ready;         // Buffer has room
   logic mack_ok;            // Master acknowledged last byte
   logic byte_end;           // Fall after eighth bit
   logic addr_hit;           // Address byte matches us
   logic mcode_hit;          // Address byte is master code

   assign sda_out = 1'b0;    // Open drain, only ever low see [R20]

   // ***********************************************
   // Pin synchronisers
   // ***********************************************
   // Two flops on each pin
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
      end
      else if (ce)
      begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         sda_m <= sda_in;
         sda_s <= sda_m;
      end
   end

   // ***********************************************
   // Clock spike filter
   // ***********************************************
   // High-speed mode needs the new level to persist
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         scl_f <= 1'b1;
         spike_cnt <= 2'h0;
      end
      else if (ce)
      begin
         if (scl_s == scl_f)
         begin
            spike_cnt <= 2'h0;
         end
         else if (!hs_mode || spike_cnt >= SPIKE_CYC)  // see [R15]
         begin
            scl_f <= scl_s;
            spike_cnt <= 2'h0;
         end
         else
         begin
            spike_cnt <= spike_cnt + 2'h1;
         end
      end
   end

   // Previous levels for edge finding
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sda_q <= 1'b1;
         scl_fq <= 1'b1;
      end
      else if (ce)
      begin
         sda_q <= sda_s;
         scl_fq <= scl_f;
      end
   end

   // Edges and conditions
   assign scl_rise = scl_f && !scl_fq;
   assign scl_fall = !scl_f && scl_fq;
   assign start_ev = scl_f && scl_fq && sda_q && !sda_s;  // see [R2] [R3] [R11]
   assign stop_ev = scl_f && scl_fq && !sda_q && sda_s;   // see [R2] [R4]
   assign byte_end = scl_fall && (bit_cnt == BITS_DONE);

   // Address decode on the received byte
   assign addr_hit = (shreg[7:1] == own_addr);                 // see [R10]
   assign mcode_hit = (shreg[7:3] == MCODE_TOP);               // see [R12]

   // ***********************************************
   // Link state machine
   // ***********************************************
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state <= ST_IDLE;
         sda_oe <= 1'b0;
         rw <= 1'b0;
         gc_phase <= GC_NONE;
         first_pend <= 1'b0;
         mack_ok <= 1'b0;
         push <= 1'b0;
         push_word <= '0;
         tx_taken <= 1'b0;
         txsh <= 8'h00;
      end
      else if (ce)
      begin
         push <= 1'b0;
         tx_taken <= 1'b0;
         if (stop_ev)
         begin
            // Stop ends everything
            state <= ST_IDLE;  // see [R4] [R9]
            sda_oe <= 1'b0;
            gc_phase <= GC_NONE;
         end
         else if (start_ev)
         begin
            // Start or repeated start opens a fresh frame
            state <= ST_ADDR;  // see [R3] [R9] [R11]
            sda_oe <= 1'b0;
            gc_phase <= GC_NONE;
         end
         else
         begin
            case (state)
               ST_ADDR:
               begin
                  if (byte_end)
                  begin
                     if (shreg == GEN_CALL_ADDR)
                     begin
                        // General call, expect one command
                        state <= ST_ACK;  // see [R6]
                        sda_oe <= 1'b1;   // see [R5]
                        rw <= 1'b0;
                        gc_phase <= GC_WAIT;
                        first_pend <= 1'b1;
                     end
                     else if (mcode_hit)
                     begin
                        // Master code, refused
                        state <= ST_SKIP;  // see [R12]
                     end
                     else if (addr_hit)
                     begin
                        // Own address, ack even if busy writing
                        state <= ST_ACK;  // see [R6] [R7]
                        sda_oe <= 1'b1;   // see [R5]
                        rw <= shreg[0];   // see [R10]
                        first_pend <= 1'b1;
                     end
                     else
                     begin
                        // Foreign address, no ack
                        state <= ST_SKIP;  // see [R6]
                     end
                  end
               end
               ST_ACK:
               begin
                  if (scl_fall)
                  begin
                     if (rw)
                     begin
                        // Load first byte for the master
                        state <= ST_TX;
                        txsh <= tx_data;
                        tx_taken <= 1'b1;
                        sda_oe <= !tx_data[7];  // see [R20]
                     end
                     else
                     begin
                        state <= ST_RX;
                        sda_oe <= 1'b0;  // see [R20]
                     end
                  end
               end
               ST_RX:
               begin
                  if (byte_end)
                  begin
                     if (gc_phase == GC_USED)
                     begin
                        // Extra general call command refused
                        state <= ST_SKIP;  // see [R16]
                     end
                     else if (gc_phase == GC_WAIT && shreg == GC_INVALID)
                     begin
                        // Forbidden command aborts the frame
                        state <= ST_SKIP;  // see [R17] [R9]
                     end
                     else if (!fifo_ready)
                     begin
                        // No room, refuse the byte
                        state <= ST_SKIP;
                     end
                     else
                     begin
                        // Accept and hand on the byte
                        state <= ST_ACK;  // see [R5]
                        sda_oe <= 1'b1;
                        push <= 1'b1;
                        push_word.gen_call <= (gc_phase == GC_WAIT);  // see [R17]
                        push_word.first <= first_pend;
                        push_word.data <= shreg;
                        first_pend <= 1'b0;
                        if (gc_phase == GC_WAIT)
                        begin
                           gc_phase <= GC_USED;  // see [R16]
                        end
                     end
                  end
               end
               ST_TX:
               begin
                  if (scl_fall)
                  begin
                     if (bit_cnt == BIT_LAST)
                     begin
                        // Release for master acknowledge
                        state <= ST_MACK;
                        sda_oe <= 1'b0;  // see [R20]
                     end
                     else
                     begin
                        txsh <= {txsh[6:0], 1'b0};
                        sda_oe <= !txsh[6];  // see [R20]
                     end
                  end
               end
               ST_MACK:
               begin
                  if (scl_rise)
                  begin
                     mack_ok <= !sda_s;  // see [R1]
                  end
                  else if (scl_fall)
                  begin
                     if (mack_ok)
                     begin
                        // Master wants more
                        state <= ST_TX;
                        txsh <= tx_data;
                        tx_taken <= 1'b1;
                        sda_oe <= !tx_data[7];
                     end
                     else
                     begin
                        // Master done, wait for condition
                        state <= ST_SKIP;  // see [R8]
                     end
                  end
               end
               default:
               begin
                  // Idle and skip wait for a condition
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   // ***********************************************
   // Bit counter and receive shifter
   // ***********************************************
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         bit_cnt <= BIT_ZERO;
         shreg <= 8'h00;
      end
      else if (ce)
      begin
         if (start_ev || stop_ev || byte_end || (scl_fall && state == ST_ACK))
         begin
            bit_cnt <= BIT_ZERO;  // see [R9]
         end
         else if (scl_rise && (state == ST_ADDR || state == ST_RX))
         begin
            shreg <= {shreg[6:0], sda_s};  // see [R1]
            bit_cnt <= bit_cnt + 4'h1;
         end
         else if (scl_fall && state == ST_TX)
         begin
            bit_cnt <= (bit_cnt == BIT_LAST) ? BIT_ZERO : bit_cnt + 4'h1;
         end
         else if (scl_fall && state == ST_MACK)
         begin
            bit_cnt <= BIT_ZERO;
         end
      end
   end

   // ***********************************************
   // Speed mode and condition pulses
   // ***********************************************
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         hs_mode <= 1'b0;
         start_seen <= 1'b0;
         stop_seen <= 1'b0;
      end
      else if (ce)
      begin
         start_seen <= start_ev;
         stop_seen <= stop_ev;
         if (stop_ev)
         begin
            hs_mode <= 1'b0;  // see [R13]
         end
         else if (state == ST_ADDR && byte_end && mcode_hit && shreg != GEN_CALL_ADDR)
         begin
            hs_mode <= 1'b1;  // see [R12] [R14]
         end
      end
   end

   // ***********************************************
   // Receive buffer
   // ***********************************************
   word_fifo #(.WIDTH($bits(rx_word_t)), .DEPTH(FIFO_DEPTH)) rx_fifo
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(push_word),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_word)
   );

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence addr_done_s;
      ce && state == ST_ADDR && byte_end;
   endsequence

   start_to_addr_a: assert property (ce && start_ev && !stop_ev |=> state == ST_ADDR && bit_cnt == BIT_ZERO) // see [R3]
      else $error("start did not open address phase");
   stop_to_idle_a: assert property (ce && stop_ev |=> state == ST_IDLE && !sda_oe) // see [R4]
      else $error("stop did not return to idle");
   hs_exit_a: assert property (ce && stop_ev |=> !hs_mode) // see [R13]
      else $error("high-speed mode kept after stop");
   hs_keep_a: assert property (ce && hs_mode && start_ev && !stop_ev |=> hs_mode) // see [R13]
      else $error("high-speed mode lost on repeated start");
   mcode_nack_a: assert property (addr_done_s ##0 (mcode_hit && shreg != GEN_CALL_ADDR)
      |=> hs_mode && !sda_oe && state == ST_SKIP) // see [R12]
      else $error("master code mishandled");
   foreign_nack_a: assert property (addr_done_s ##0 (!addr_hit && shreg != GEN_CALL_ADDR)
      |=> !sda_oe) // see [R6]
      else $error("foreign address acknowledged");
   own_ack_a: assert property (addr_done_s ##0 (addr_hit && !mcode_hit) |=> sda_oe && state == ST_ACK) // see [R5]
      else $error("own address not acknowledged");
   drive_owed_a: assert property (sda_oe |-> state == ST_ACK || state == ST_TX) // see [R20]
      else $error("data driven outside owed bits");
   oe_quiet_a: assert property ($changed(sda_oe) |-> !scl_f) // see [R2]
      else $error("data drive changed while clock high");
   gc_once_a: assert property (ce && state == ST_RX && byte_end && gc_phase == GC_USED |=> !sda_oe && !push) // see [R16]
      else $error("second general call command accepted");
   sample_a: assert property (ce && scl_rise && state == ST_RX && !start_ev && !stop_ev
      |=> shreg[0] == $past(sda_s)) // see [R1]
      else $error("data not sampled on clock rise");
endmodule

// ---- twowire_pkg.sv ----
package twowire_pkg;
   // ***********************************************
   // Timing
   // ***********************************************
   localparam int CLK_MHZ = 40;   // Reference clock rate
   localparam int SPIKE_NS = 10;  // Longest clock spike rejected in high-speed mode
   localparam int SPIKE_CYC_RAW = (SPIKE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [1:0] SPIKE_CYC = (SPIKE_CYC_RAW < 1) ? 2'h1 : 2'(SPIKE_CYC_RAW);

   // ***********************************************
   // Byte layout and special codes
   // ***********************************************
   localparam logic [3:0] BITS_DONE = 4'h8;       // Bits per byte
   localparam logic [3:0] BIT_LAST = 4'h7;        // Index of last bit sent
   localparam logic [3:0] BIT_ZERO = 4'h0;        // Counter restart
   localparam logic [7:0] GEN_CALL_ADDR = 8'h00;  // General call address, write
   localparam logic [7:0] GC_INVALID = 8'h00;     // Forbidden second byte
   localparam logic [4:0] MCODE_TOP = 5'h01;      // Upper five bits of master code
   localparam logic [1:0] GC_NONE = 2'h0;         // No general call active
   localparam logic [1:0] GC_WAIT = 2'h1;         // Awaiting the one command
   localparam logic [1:0] GC_USED = 2'h2;         // Command already taken
   localparam int FIFO_DEPTH = 32;                // Received word buffer depth

   // ***********************************************
   // Types
   // ***********************************************
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,  // Bus free
      ST_ADDR = 3'h1,  // Shifting in the address byte
      ST_ACK = 3'h3,   // Driving acknowledge
      ST_RX = 3'h2,    // Shifting in a data byte
      ST_TX = 3'h6,    // Shifting out a data byte
      ST_MACK = 3'h7,  // Master acknowledge slot
      ST_SKIP = 3'h5   // Ignoring until start or stop
   } link_state_t;

   // One received word for the user side
   typedef struct packed
   {
      logic gen_call;   // Command came after general call
      logic first;      // First byte after the address
      logic [7:0] data; // Byte value
   } rx_word_t;
endpackage

// ---- word_fifo.sv ----
`timescale 1ns/1ps
module word_fifo
   #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 32
   )
   (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
   );
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];  // Word storage
   logic [AW:0] wr_ptr;            // Write pointer with wrap bit
   logic [AW:0] rd_ptr;            // Read pointer with wrap bit
   logic push;                     // Word accepted
   logic pop;                      // Word drained

   // Full when pointers differ only in wrap bit
   assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign out_valid = (wr_ptr != rd_ptr);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr[AW-1:0]];

   // Storage write
   always_ff @(posedge ref_clk)
   begin
      if (ce && push)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   // Pointer update
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else if (ce)
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule

// ---- twowire_master_model.sv ----
`timescale 1ns/1ps
// ****************************************
// Bus master model, open-drain outputs
// ****************************************
module twowire_master_model
   (
   input wire logic ref_clk,
   input wire logic sda_wire,
   output logic scl_low,
   output logic sda_low
   );
   // Both lines released at power-up
   initial
   begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // Wait whole reference cycles
   task automatic w(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // Start or repeated start, clock left low
   task automatic start_cond();
      w(3);
      sda_low = 1'b0;
      w(2);
      scl_low = 1'b0;
      w(5);
      sda_low = 1'b1;
      w(4);
      scl_low = 1'b1;
   endtask
   // Stop, bus left idle with clock standing high
   task automatic stop_cond();
      w(3);
      sda_low = 1'b1;
      w(2);
      scl_low = 1'b0;
      w(5);
      sda_low = 1'b0;
      w(6);
   endtask
   // One reference-cycle high pulse on a low clock, data untouched
   task automatic scl_spike();
      w(6);
      scl_low = 1'b0;
      w(1);
      scl_low = 1'b1;
   endtask
   // One 200 ns clock; data changes well inside the low phase
   task automatic clock_bit(input logic b, output logic got);
      w(3);
      sda_low = !b;
      w(2);
      scl_low = 1'b0;
      w(2);
      got = sda_wire;
      w(1);
      scl_low = 1'b1;
   endtask
   // Byte out MSB first, then the acknowledge slot
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--)
         clock_bit(d[i], g);
      clock_bit(1'b1, g);
      ack = !g;
   endtask
   // Byte in, then our own acknowledge or not
   task automatic recv_byte(input logic give_ack, output logic [7:0] d);
      logic g;
      for (int i = 7; i >= 0; i--)
      begin
         clock_bit(1'b1, g);
         d[i] = g;
      end
      clock_bit(!give_ack, g);
   endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import twowire_pkg::*;
   // Address table row
   typedef struct {logic [7:0] addr; logic ack; logic hs;} row_t;
   logic ref_clk, rst, ce, scl_low, sda_low, sda_out, sda_oe, scl_wire, sda_wire;
   logic tx_taken, rx_valid, rx_ready, hs_mode, start_seen, stop_seen, ack;
   logic [6:0] own_addr;
   logic [7:0] tx_data, d;
   rx_word_t rx_word;
   int mismatches, compares, n_start, n_stop, n_tx, s0, p0;
   row_t rows [6];
   // Pull-ups on both lines
   assign scl_wire = !scl_low;
   assign sda_wire = !(sda_low || (sda_oe && !sda_out));
   twowire_slave twowire_slave_inst
   (
   .ref_clk(ref_clk), .rst(rst), .ce(ce), .scl_in(scl_wire), .sda_in(sda_wire),
   .sda_out(sda_out), .sda_oe(sda_oe), .own_addr(own_addr), .tx_data(tx_data),
   .tx_taken(tx_taken), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word),
   .hs_mode(hs_mode), .start_seen(start_seen), .stop_seen(stop_seen)
   );
   twowire_master_model twowire_master_model_inst
   (
   .ref_clk(ref_clk), .sda_wire(sda_wire), .scl_low(scl_low), .sda_low(sda_low)
   );
   // ****************************************
   // Clock, pulse counters, checks
   // ****************************************
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Count single-cycle pulses
   always @(posedge ref_clk)
   begin
      if (start_seen === 1'b1) n_start++;
      if (stop_seen === 1'b1) n_stop++;
      if (tx_taken === 1'b1) n_tx++;
   end
   task automatic chk_bit(input string name, input logic e, input logic g);
      compares++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s expected %b seen %b", name, e, g);
      end
   endtask
   task automatic chk_val(input string name, input logic [9:0] e, input logic [9:0] g);
      compares++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic print_verdict();
      if (mismatches == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Bus shorthands
   task automatic st();
      twowire_master_model_inst.start_cond();
   endtask
   task automatic sp();
      twowire_master_model_inst.stop_cond();
   endtask
   task automatic sb(input logic [7:0] v);
      twowire_master_model_inst.send_byte(v, ack);
   endtask
   // Take one word from the buffer
   task automatic pop(input logic [9:0] e);
      int k;
      k = 0;
      do
      begin
         @(negedge ref_clk);
         k++;
      end
      while (rx_valid !== 1'b1 && k < 100);
      chk_bit("rx_valid", 1'b1, rx_valid);
      chk_val("rx_word", e, rx_word);
      rx_ready = 1'b1;
      @(negedge ref_clk);
      rx_ready = 1'b0;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      rx_ready = 1'b0;
      own_addr = 7'h2a;
      tx_data = 8'hc3;
      rows = '{'{8'h54, 1'b1, 1'b0}, '{8'h56, 1'b0, 1'b0}, '{8'h00, 1'b1, 1'b0},
               '{8'h0f, 1'b0, 1'b1}, '{8'h08, 1'b0, 1'b1}, '{8'hab, 1'b0, 1'b0}};
      repeat (6) @(negedge ref_clk);
      rst = 1'b0;
      chk_bit("sda_oe", 1'b0, sda_oe);
      chk_bit("hs_mode", 1'b0, hs_mode);
      chk_bit("rx_valid", 1'b0, rx_valid);
      foreach (rows[i])
      begin
         s0 = n_start;
         p0 = n_stop;
         st();
         sb(rows[i].addr);
         chk_bit("ack", rows[i].ack, ack);
         chk_bit("hs_mode", rows[i].hs, hs_mode);
         sp();
         chk_bit("hs_mode", 1'b0, hs_mode);
         chk_val("starts", 10'h001, 10'(n_start - s0));
         chk_val("stops", 10'h001, 10'(n_stop - p0));
      end
      // Two data bytes in one write; a frozen clock enable keeps the buffer
      st();
      sb(8'h54);
      sb(8'ha5);
      chk_bit("ack", 1'b1, ack);
      sb(8'h3c);
      sp();
      ce = 1'b0;
      rx_ready = 1'b1;
      repeat (2) @(negedge ref_clk);
      rx_ready = 1'b0;
      ce = 1'b1;
      pop(10'h1a5);
      pop(10'h03c);
      // Partial byte cut by a repeated start is dropped
      st();
      sb(8'h54);
      for (int i = 0; i < 4; i++)
         twowire_master_model_inst.clock_bit(i[0], d[0]);
      st();
      sb(8'h54);
      chk_bit("ack", 1'b1, ack);
      sb(8'h77);
      sp();
      pop(10'h177);
      chk_bit("rx_valid", 1'b0, rx_valid);
      // Master code, then repeated start in high-speed mode with a clock spike
      st();
      sb(8'h0a);
      chk_bit("ack", 1'b0, ack);
      st();
      sb(8'h54);
      chk_bit("hs_mode", 1'b1, hs_mode);
      twowire_master_model_inst.scl_spike();
      sb(8'h11);
      chk_bit("ack", 1'b1, ack);
      sp();
      chk_bit("hs_mode", 1'b0, hs_mode);
      pop(10'h111);
      // General call: one command only, zero refused, odd accepted
      st();
      sb(8'h00);
      sb(8'h04);
      chk_bit("ack", 1'b1, ack);
      sb(8'h06);
      chk_bit("ack", 1'b0, ack);
      sp();
      pop(10'h304);
      st();
      sb(8'h00);
      sb(8'h00);
      chk_bit("ack", 1'b0, ack);
      sp();
      st();
      sb(8'h00);
      sb(8'h07);
      chk_bit("ack", 1'b1, ack);
      sp();
      pop(10'h307);
      // Read one byte, master declines more
      s0 = n_tx;
      st();
      sb(8'h55);
      twowire_master_model_inst.recv_byte(1'b0, d);
      chk_val("read", {2'h0, tx_data}, {2'h0, d});
      sp();
      chk_val("loads", 10'h001, 10'(n_tx - s0));
      chk_bit("sda_oe", 1'b0, sda_oe);
      // Fill the buffer while the reader stalls, then drain it
      st();
      sb(8'h54);
      for (int i = 0; i < 33; i++)
      begin
         sb(8'(i));
         chk_bit("ack", i < 32, ack);
      end
      sp();
      for (int i = 0; i < 32; i++)
         pop({1'b0, i == 0, 8'(i)});
      chk_bit("rx_valid", 1'b0, rx_valid);
      // Reset in mid frame clears speed mode and buffer
      st();
      sb(8'h0a);
      st();
      sb(8'h54);
      sb(8'h5a);
      chk_bit("rx_valid", 1'b1, rx_valid);
      rst = 1'b1;
      repeat (6) @(negedge ref_clk);
      rst = 1'b0;
      chk_bit("hs_mode", 1'b0, hs_mode);
      chk_bit("sda_oe", 1'b0, sda_oe);
      chk_bit("rx_valid", 1'b0, rx_valid);
      p0 = n_stop;
      sp();
      chk_val("stops", 10'h001, 10'(n_stop - p0));
      st();
      sb(8'h54);
      chk_bit("ack", 1'b1, ack);
      sp();
      print_verdict();
   end
   // Hang guard
   initial
   begin
      #1000000;
      mismatches++;
      print_verdict();
   end
endmodule
